/* design/cce_clock_ctrl.sv */
// clock enable, source select, dividers and write gating of the codec
`timescale 1ns/10ps
`default_nettype none

module cce_clock_ctrl
	import cce_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic [9:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_ext_clk,
	input wire logic i_pll_clk,
	input wire logic i_pll_lock,
	input wire logic i_spi_mode,
	input wire logic i_dsp_clk_en,
	input wire logic i_sda,
	input wire logic i_scl,
	output logic o_sda_filt,
	output logic o_scl_filt,
	output logic o_pll_power_en,
	output logic o_pll_clk_active,
	output logic o_xtal_disable,
	output logic o_core_clk,
	output logic o_mclk,
	output logic o_gen_wr_en,
	output logic o_param_wr_en
);

	cce_state_s s;
	cce_state_s next_s;

	logic req;
	logic commit;
	logic flt_byp;
	logic pll_g;
	logic src;
	logic rise;
	logic cfg_safe;

	function automatic cce_flt_s flt_step(cce_flt_s f, logic din,
		logic byp);
		cce_flt_s r;
		r = f;
		if (byp) begin
			r.lvl = din;
			r.cnt = 3'h0;
		end else if (din == f.lvl) begin
			r.cnt = 3'h0;
		end else if (f.cnt == FLT_LAST) begin
			r.lvl = din;
			r.cnt = 3'h0;
		end else begin
			r.cnt = f.cnt + 3'h1;
		end
		return r;
	endfunction : flt_step

	function automatic logic div_step(logic q, logic div1, logic sq,
		logic rs);
		logic r;
		r = div1 ? sq : (q ^ rs);
		return r;
	endfunction : div_step

	assign req = i_avs_read | i_avs_write;
	assign commit = req & (s.phase == BP_ACK);
	assign flt_byp = s.ctrl[BIT_FLT_BYP] | i_spi_mode;
	assign pll_g = i_pll_clk & s.pll_act;
	assign src = s.cfg.sel ? pll_g : i_ext_clk;
	assign rise = src & ~s.src_q;
	// switch only while the live source and both outputs are low;
	// watching the idle source too could lock out a switch forever
	assign cfg_safe = ~src & ~s.core_clk & ~s.mclk;

	always_comb begin
		next_s = s;
		// one wait cycle, then a single acknowledge cycle
		next_s.phase = (req && s.phase == BP_WAIT) ? BP_ACK : BP_WAIT;
		if (req && s.phase == BP_WAIT && i_avs_read) begin
			next_s.rdata = 32'h0000_0000;
			if (i_avs_address == CLK_CTRL_ADDR) begin
				next_s.rdata[7:0] = s.ctrl;
			end else if (i_avs_address == PLL_STAT_ADDR) begin
				next_s.rdata[BIT_LOCK] = i_pll_lock;
			end
		end
		// this register always writable, also with the gate off
		if (commit && i_avs_write && i_avs_byteenable[0] &&
			i_avs_address == CLK_CTRL_ADDR) begin
			next_s.ctrl = i_avs_writedata[7:0] & CLK_CTRL_WMASK;
		end
		next_s.pll_act = next_s.ctrl[BIT_PLL_EN] &
			next_s.ctrl[BIT_GATE_EN];
		next_s.gen_wr = next_s.ctrl[BIT_GATE_EN];
		next_s.param_wr = next_s.ctrl[BIT_GATE_EN] & i_dsp_clk_en;
		next_s.sda = flt_step(s.sda, i_sda, flt_byp);
		next_s.scl = flt_step(s.scl, i_scl, flt_byp);
		next_s.src_q = src;
		if (s.cfg.gate) begin
			next_s.core_clk = div_step(s.core_clk, s.cfg.cdiv,
				src, rise);
			next_s.mclk = div_step(s.mclk, s.cfg.mdiv,
				src, rise);
		end else begin
			next_s.core_clk = 1'b0;
			next_s.mclk = 1'b0;
		end
		// a source stuck high delays the switch until it falls
		if (cfg_safe) begin
			next_s.cfg.sel = s.ctrl[BIT_CLK_SEL];
			next_s.cfg.cdiv = s.ctrl[BIT_CDIV];
			next_s.cfg.mdiv = s.ctrl[BIT_MDIV];
			next_s.cfg.gate = s.ctrl[BIT_GATE_EN];
			next_s.src_q = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			s.ctrl <= CLK_CTRL_RESET;
			s.phase <= BP_WAIT;
			s.rdata <= 32'h0000_0000;
			s.src_q <= 1'b0;
			s.cfg <= CFG_RESET;
			s.core_clk <= 1'b0;
			s.mclk <= 1'b0;
			s.pll_act <= 1'b0;
			s.gen_wr <= 1'b0;
			s.param_wr <= 1'b0;
			s.sda <= FLT_RESET;
			s.scl <= FLT_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign o_avs_readdata = s.rdata;
	assign o_avs_waitrequest = s.phase;
	assign o_sda_filt = s.sda.lvl;
	assign o_scl_filt = s.scl.lvl;
	assign o_pll_power_en = s.ctrl[BIT_PLL_EN];
	assign o_pll_clk_active = s.pll_act;
	assign o_xtal_disable = s.ctrl[BIT_CRYSTAL_OSC_DISABLE];
	assign o_core_clk = s.core_clk;
	assign o_mclk = s.mclk;
	assign o_gen_wr_en = s.gen_wr;
	assign o_param_wr_en = s.param_wr;

	logic wr_ctrl;
	assign wr_ctrl = commit & i_avs_write & i_avs_byteenable[0] &
		(i_avs_address == CLK_CTRL_ADDR);

	chk_pll_power_off: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		wr_ctrl && !i_avs_writedata[BIT_PLL_EN]
		|=> !o_pll_power_en && !o_pll_clk_active)
		else $error("pll stays powered after enable cleared");

	chk_pll_clk_gate: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		o_pll_clk_active
		|-> o_pll_power_en && s.ctrl[BIT_GATE_EN])
		else $error("pll clock active without both enables");

	chk_filter_hold: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		$changed(o_sda_filt) && !$past(flt_byp)
		|-> $past(i_sda, 1) == o_sda_filt &&
			$past(i_sda, 5) == o_sda_filt)
		else $error("filter passed a short spike");

	chk_filter_bypass: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		i_spi_mode |=> o_scl_filt == $past(i_scl))
		else $error("filter not bypassed in four-wire mode");

	chk_src_ext: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		s.cfg.gate && !s.cfg.sel && s.cfg.cdiv && !cfg_safe
		|=> o_core_clk == $past(i_ext_clk, 1))
		else $error("core clock not following external pin");

	chk_core_div2: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		s.cfg.gate && !s.cfg.cdiv && rise
		|=> o_core_clk != $past(o_core_clk))
		else $error("core divide by two missed an edge");

	chk_mclk_div2: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		s.cfg.gate && !s.cfg.mdiv && !rise
		|=> $stable(o_mclk))
		else $error("master clock toggled without source edge");

	chk_wr_gate: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		wr_ctrl && !i_avs_writedata[BIT_GATE_EN]
		|=> !o_gen_wr_en && !o_param_wr_en)
		else $error("writes allowed with main clock gate off");

	chk_param_gate: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		o_param_wr_en |-> o_gen_wr_en && $past(i_dsp_clk_en))
		else $error("parameter write allowed before core enable");

	chk_lock_read: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		i_avs_read && s.phase == BP_WAIT &&
		i_avs_address == PLL_STAT_ADDR
		|=> !o_avs_waitrequest &&
			o_avs_readdata == {31'h0000_0000, $past(i_pll_lock)})
		else $error("lock flag read back wrong");

	chk_no_runt: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		$changed(s.cfg) |-> !o_core_clk && !o_mclk)
		else $error("clock config switched while a clock was high");

	cov_ctrl_write: cover property (@(posedge i_sys_clk)
		disable iff (i_srst) wr_ctrl);
	cov_lock_read: cover property (@(posedge i_sys_clk)
		disable iff (i_srst)
		commit && i_avs_read && i_avs_address == PLL_STAT_ADDR);
	cov_pll_src: cover property (@(posedge i_sys_clk)
		disable iff (i_srst) s.cfg.sel && $rose(o_core_clk));
	cov_filter_flip: cover property (@(posedge i_sys_clk)
		disable iff (i_srst) !flt_byp && $changed(o_sda_filt));

endmodule : cce_clock_ctrl

`default_nettype wire

/* include/cce_pkg.sv */
// package for the codec clock enable control block
package cce_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int FLT_TIME_NS = 50;
	// least time, rounded up to whole cycles
	localparam int FLT_CYC =
		(FLT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] FLT_LAST = 3'(FLT_CYC - 1);

	localparam int CLK_CTRL_IDX = 0;
	localparam int PLL_STAT_IDX = 6;
	localparam logic [9:0] CLK_CTRL_ADDR = 10'(CLK_CTRL_IDX * 4);
	localparam logic [9:0] PLL_STAT_ADDR = 10'(PLL_STAT_IDX * 4);

	localparam int BIT_PLL_EN = 7;
	localparam int BIT_FLT_BYP = 5;
	localparam int BIT_CRYSTAL_OSC_DISABLE = 4;
	localparam int BIT_CLK_SEL = 3;
	localparam int BIT_CDIV = 2;
	localparam int BIT_MDIV = 1;
	localparam int BIT_GATE_EN = 0;
	localparam int BIT_LOCK = 0;

	localparam logic [7:0] CLK_CTRL_RESET = 8'h00;
	// bit 6 is reserved: never stored, reads zero
	localparam logic [7:0] CLK_CTRL_WMASK = 8'hBF;
	localparam logic FLT_IDLE = 1'b1;

	typedef enum logic {
		BP_ACK = 1'b0,
		BP_WAIT = 1'b1
	} cce_phase_e;

	typedef struct packed {
		logic sel;
		logic cdiv;
		logic mdiv;
		logic gate;
	} cce_cfg_s;

	typedef struct packed {
		logic lvl;
		logic [2:0] cnt;
	} cce_flt_s;

	typedef struct packed {
		logic [7:0] ctrl;
		cce_phase_e phase;
		logic [31:0] rdata;
		logic src_q;
		cce_cfg_s cfg;
		logic core_clk;
		logic mclk;
		logic pll_act;
		logic gen_wr;
		logic param_wr;
		cce_flt_s sda;
		cce_flt_s scl;
	} cce_state_s;

	localparam cce_cfg_s CFG_RESET = '{sel: 1'b0, cdiv: 1'b0,
		mdiv: 1'b0, gate: 1'b0};
	localparam cce_flt_s FLT_RESET = '{lvl: FLT_IDLE, cnt: 3'h0};
endpackage : cce_pkg

/* test/cce_clock_ctrl_test.sv */
// self-checking bench for the clock enable control block
`timescale 1ns/10ps
`default_nettype none
module cce_clock_ctrl_test
	import cce_pkg::*;
;
	logic clk, srst, rd, wr, lock, spi, dsp, sda, scl, ext, pll;
	logic [9:0] adr;
	logic [31:0] wd, q, rdat, r;
	logic [3:0] be;
	logic wreq, sf, cf, pwr, act, xtal, core, mclk, gen, prm;
	logic [7:0] c;
	int fail_count, compares, cyc, m, lo, ec, em, p;
	bit en;

	cce_clock_ctrl i_dut (
		.i_sys_clk(clk),
		.i_srst(srst),
		.i_avs_address(adr),
		.i_avs_read(rd),
		.i_avs_write(wr),
		.i_avs_writedata(wd),
		.i_avs_byteenable(be),
		.o_avs_readdata(rdat),
		.o_avs_waitrequest(wreq),
		.i_ext_clk(ext),
		.i_pll_clk(pll),
		.i_pll_lock(lock),
		.i_spi_mode(spi),
		.i_dsp_clk_en(dsp),
		.i_sda(sda),
		.i_scl(scl),
		.o_sda_filt(sf),
		.o_scl_filt(cf),
		.o_pll_power_en(pwr),
		.o_pll_clk_active(act),
		.o_xtal_disable(xtal),
		.o_core_clk(core),
		.o_mclk(mclk),
		.o_gen_wr_en(gen),
		.o_param_wr_en(prm)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// source clocks: pin period 4 cycles, pll period 8 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		ext <= cyc[1];
		pll <= cyc[2];
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
		end
	endtask : chk

	task automatic close_out;
		$display("mismatches %0d compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	task automatic av(input logic rq, input logic [9:0] a,
		input logic [31:0] d, input logic [3:0] b);
		int n;
		n = 0;
		rd <= rq;
		wr <= ~rq;
		adr <= a;
		wd <= d;
		be <= b;
		do begin
			@(posedge clk);
			n++;
			if (n > 20) begin
				fail_count++;
				close_out();
			end
		end while (wreq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask : av

	task automatic pulse(input int len);
		lo = 0;
		sda <= 1'b0;
		scl <= 1'b0;
		for (int i = 0; i < len + 8; i++) begin
			@(negedge clk);
			lo += int'(sf === 1'b0 && cf === 1'b0);
			@(posedge clk);
			if (i == len - 1) begin
				sda <= 1'b1;
				scl <= 1'b1;
			end
		end
	endtask : pulse

	// rising edges over 80 cycles, after the switch has settled
	task automatic count_edges;
		logic pc, pm;
		repeat (40) @(posedge clk);
		@(negedge clk);
		{pc, pm} = {core, mclk};
		ec = 0;
		em = 0;
		repeat (80) begin
			@(negedge clk);
			ec += int'(core === 1'b1 && pc === 1'b0);
			em += int'(mclk === 1'b1 && pm === 1'b0);
			{pc, pm} = {core, mclk};
		end
		@(posedge clk);
	endtask : count_edges

	initial begin
		{srst, rd, wr, adr, wd, be, lock, spi, dsp} = '0;
		srst = 1'b1;
		{sda, scl, fail_count, compares} = '0;
		{sda, scl} = 2'h3;
		r = $urandom(32'h0ECD502E);
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk({sf, cf, pwr, act, xtal, core, mclk, gen, prm, wreq}, 10'h301);
		av(1'b1, CLK_CTRL_ADDR, 32'h0, 4'hF);
		chk(q, 32'h0);
		av(1'b0, 10'h004, 32'hFF, 4'hF);
		repeat (8) begin
			r = $urandom;
			c = 8'($urandom) & (r[1] ? 8'hFF : 8'hF6);
			dsp <= r[0];
			lock <= r[1];
			av(1'b0, CLK_CTRL_ADDR, {r[31:8], c}, 4'hF);
			m = int'(c & CLK_CTRL_WMASK);
			chk({pwr, act, xtal}, {c[7], c[7] & c[0], c[4]});
			chk({gen, prm}, {c[0], c[0] & r[0]});
			av(1'b1, CLK_CTRL_ADDR, 32'h0, 4'hF);
			chk(q, m);
			av(1'b1, PLL_STAT_ADDR, 32'h0, 4'hF);
			chk(q, {31'h0, r[1]});
		end
		av(1'b0, CLK_CTRL_ADDR, 32'hFF, 4'hE);
		av(1'b1, CLK_CTRL_ADDR, 32'h0, 4'hF);
		chk(q, m);
		av(1'b1, 10'h004, 32'h0, 4'hF);
		chk(q, 32'h0);
		dsp <= 1'b0;
		av(1'b0, CLK_CTRL_ADDR, 32'h01, 4'hF);
		chk(prm, 1'b0);
		dsp <= 1'b1;
		repeat (3) @(posedge clk);
		chk(prm, 1'b1);
		for (int k = 0; k < 3; k++) begin
			av(1'b0, CLK_CTRL_ADDR, (k == 1) ? 32'h20 : 32'h0, 4'hF);
			spi <= (k == 2);
			pulse(4);
			chk(lo, (k == 0) ? 0 : 4);
		end
		spi <= 1'b0;
		pulse(6);
		chk(lo > 0, 1'b1);
		// pll gated and routed by bits 7, 3 and 0
		lock <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			c = (i < 8) ? 8'h81 | 8'(i << 1) : ((i == 8) ? 8'h0E : 8'h0F);
			av(1'b0, CLK_CTRL_ADDR, {24'h0, c}, 4'hF);
			p = c[3] ? 8 : 4;
			en = c[0] && (c[7] || !c[3]);
			count_edges();
			chk(ec, en ? 80 / (c[2] ? p : 2 * p) : 0);
			chk(em, en ? 80 / (c[1] ? p : 2 * p) : 0);
		end
		close_out();
	end
endmodule : cce_clock_ctrl_test
`default_nettype wire
